// File: rtl/voice_ctrl_pkg.sv
// Constants shared by the voice control register bank and its host
package voice_ctrl_pkg;
    // ------------------------------------------------------------
    // Register indices, used directly as host addresses
    // ------------------------------------------------------------
    localparam logic [4:0] IDX_BASIC_MODE  = 5'h00;
    localparam logic [4:0] IDX_CODEC_PATH  = 5'h01;
    localparam logic [4:0] IDX_SLOT_ASSIGN = 5'h02;
    localparam logic [4:0] IDX_ROUTING     = 5'h03;
    localparam logic [4:0] IDX_TONE_GAIN   = 5'h04;
    localparam logic [4:0] IDX_TONE_SELECT = 5'h05;
    localparam logic [4:0] IDX_STATUS      = 5'h06;
    localparam logic [4:0] IDX_COMMAND     = 5'h07;
    localparam logic [4:0] IDX_LAST        = 5'h05;
    // Writable bit masks, unused bits read zero
    localparam logic [7:0] MASK_BASIC_MODE  = 8'h6f;
    localparam logic [7:0] MASK_SLOT_ASSIGN = 8'h1f;
    localparam logic [7:0] MASK_ROUTING     = 8'h60;
    localparam logic [7:0] MASK_FULL        = 8'hff;
    localparam logic [7:0] RESET_VALUE      = 8'h00;
    // Field positions
    localparam int POS_POWERDOWN     = 6;
    localparam int POS_PD_RESET      = 5;
    localparam int POS_MODE_B2       = 2;
    localparam int POS_MODE_B0       = 0;
    localparam int POS_CODEC_THROUGH = 7;
    localparam int POS_XCODER_RESET  = 6;
    localparam int POS_WHOLE_THROUGH = 5;
    localparam int POS_TX_MUTE       = 4;
    localparam int POS_RX_MUTE       = 3;
    localparam int POS_XCODER_SLOT   = 4;
    localparam int POS_DUAL_TONE     = 7;
    localparam int POS_TX_TONE_SEND  = 6;
    localparam int POS_RX_TONE_SEND  = 5;
    // Operating mode codes
    localparam logic [3:0] MODE_INITIAL   = 4'h0;
    localparam logic [3:0] MODE_HANDSFREE = 4'h4;
    localparam logic [3:0] MODE_LINE_EXP  = 4'h5;
    localparam logic [2:0] ATTEN_MUTE     = 3'h7;
    // Tone gain coefficient values
    localparam logic [15:0] TONE_COEF_DEFAULT = 16'h4000;
    localparam logic [15:0] TONE_COEF_MINUS1  = 16'h390a;
    localparam logic [8:0]  TONE_COEF_ADDR    = 9'h16d;
    // Timing: initial-mode entry delay
    localparam int CLK_HZ           = 100_000_000;
    localparam int INIT_DELAY_MS    = 200;
    localparam int INIT_DELAY_CYC   = CLK_HZ / 1000 * INIT_DELAY_MS;
    localparam int HOST_CMD_WRITE   = 1;
    localparam int HOST_CMD_READ    = 0;
endpackage

// File: rtl/voice_ctrl_if.sv
// Parallel register port between host controller and register bank
`timescale 1ns/1ns
`default_nettype none
interface voice_ctrl_if;
    logic       cs_n;
    logic       wr_n;
    logic       rd_n;
    logic [4:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic       rdata_oe;
    logic       powerdown_n;
    logic       powerdown_reset_n;

    modport device (
        input  cs_n,
        input  wr_n,
        input  rd_n,
        input  addr,
        input  wdata,
        output rdata,
        output rdata_oe,
        input  powerdown_n,
        input  powerdown_reset_n
    );
    modport host (
        output cs_n,
        output wr_n,
        output rd_n,
        output addr,
        output wdata,
        input  rdata,
        input  rdata_oe,
        output powerdown_n,
        output powerdown_reset_n
    );
endinterface
`default_nettype wire

// File: rtl/voice_ctrl_regs.sv
// Control register bank of the voice processor, device end
`timescale 1ns/1ns
`default_nettype none
module voice_ctrl_regs #(
    parameter int INIT_DELAY = voice_ctrl_pkg::INIT_DELAY_CYC
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    voice_ctrl_if.device     bus,
    input  wire logic        host_control_select_pin_i,
    input  wire logic        echo_mode_pin_i,
    input  wire logic        codec_through_pin_i,
    input  wire logic        mute_pin_i,
    output logic             powered_down_o,
    output logic             in_reset_o,
    output logic             initial_mode_o,
    output logic [3:0]       operating_mode_code_o,
    output logic             handsfree_o,
    output logic             line_expansion_o,
    output logic             canceler_enable_o,
    output logic             transcoder_enable_o,
    output logic             pcm_idle_o,
    output logic             pcm_out_hiz_o,
    output logic             codec_through_o,
    output logic             transcoder_state_reset_o,
    output logic             whole_path_through_o,
    output logic             tx_mute_o,
    output logic [2:0]       receive_attenuation_code_o,
    output logic             rx_full_mute_o,
    output logic [1:0]       transcoder_slot_o,
    output logic [1:0]       line_canceler_slot_select_o,
    output logic [1:0]       acoustic_canceler_slot_select_o,
    output logic [1:0]       pcm_io_routing_o,
    output logic [3:0]       transmit_tone_gain_o,
    output logic [3:0]       receive_tone_gain_o,
    output logic             dual_tone_select_o,
    output logic             tx_tone_send_o,
    output logic             rx_tone_send_o,
    output logic [4:0]       tone_code_o
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum logic [1:0] {ST_RESET, ST_WAIT, ST_INITIAL, ST_RUN} phase_t;

    typedef struct packed {
        logic [7:0]  basic_mode;
        logic [7:0]  codec_path;
        logic [7:0]  slot_assign;
        logic [7:0]  routing;
        logic [7:0]  tone_gain;
        logic [7:0]  tone_select;
        phase_t      phase;
        logic [31:0] delay_cnt;
        logic        wr_seen;
        logic        xcoder_reset;
        logic        hiz;
        logic [7:0]  rdata;
    } state_t;

    state_t state_r;
    state_t state_nxt;

    function automatic logic [7:0] reg_mask(input logic [4:0] idx);
        case (idx)
            voice_ctrl_pkg::IDX_BASIC_MODE:  reg_mask = voice_ctrl_pkg::MASK_BASIC_MODE;
            voice_ctrl_pkg::IDX_SLOT_ASSIGN: reg_mask = voice_ctrl_pkg::MASK_SLOT_ASSIGN;
            voice_ctrl_pkg::IDX_ROUTING:     reg_mask = voice_ctrl_pkg::MASK_ROUTING;
            default:                         reg_mask = voice_ctrl_pkg::MASK_FULL;
        endcase
    endfunction

    logic       wr_pulse;
    logic       rd_active;
    logic       pd_level;
    logic       rst_level;
    logic [3:0] eff_mode;

    assign wr_pulse  = !bus.cs_n && !bus.wr_n && !state_r.wr_seen;
    assign rd_active = !bus.cs_n && !bus.rd_n;
    assign pd_level  = state_r.basic_mode[voice_ctrl_pkg::POS_POWERDOWN]
                       || !bus.powerdown_n;
    assign rst_level = state_r.basic_mode[voice_ctrl_pkg::POS_PD_RESET]
                       || !bus.powerdown_reset_n;
    assign eff_mode = {state_r.basic_mode[3],
                       state_r.basic_mode[2] | host_control_select_pin_i,
                       state_r.basic_mode[1],
                       state_r.basic_mode[0] | echo_mode_pin_i};

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        state_nxt.wr_seen = !bus.cs_n && !bus.wr_n;
        state_nxt.xcoder_reset = 1'b0;
        if (wr_pulse && bus.addr <= voice_ctrl_pkg::IDX_LAST) begin
            case (bus.addr)
                voice_ctrl_pkg::IDX_BASIC_MODE:  state_nxt.basic_mode =
                    bus.wdata & reg_mask(bus.addr);
                voice_ctrl_pkg::IDX_CODEC_PATH: begin
                    state_nxt.codec_path = bus.wdata;
                    state_nxt.xcoder_reset =
                        bus.wdata[voice_ctrl_pkg::POS_XCODER_RESET];
                end
                voice_ctrl_pkg::IDX_SLOT_ASSIGN: state_nxt.slot_assign =
                    bus.wdata & reg_mask(bus.addr);
                voice_ctrl_pkg::IDX_ROUTING:     state_nxt.routing =
                    bus.wdata & reg_mask(bus.addr);
                voice_ctrl_pkg::IDX_TONE_GAIN:   state_nxt.tone_gain = bus.wdata;
                default:                         state_nxt.tone_select = bus.wdata;
            endcase
        end
        case (bus.addr)
            voice_ctrl_pkg::IDX_BASIC_MODE:  state_nxt.rdata = state_r.basic_mode;
            voice_ctrl_pkg::IDX_CODEC_PATH:  state_nxt.rdata = state_r.codec_path;
            voice_ctrl_pkg::IDX_SLOT_ASSIGN: state_nxt.rdata = state_r.slot_assign;
            voice_ctrl_pkg::IDX_ROUTING:     state_nxt.rdata = state_r.routing;
            voice_ctrl_pkg::IDX_TONE_GAIN:   state_nxt.rdata = state_r.tone_gain;
            voice_ctrl_pkg::IDX_TONE_SELECT: state_nxt.rdata = state_r.tone_select;
            default:                         state_nxt.rdata = voice_ctrl_pkg::RESET_VALUE;
        endcase
        case (state_r.phase)
            ST_RESET: begin
                state_nxt.delay_cnt = '0;
                if (!rst_level && !pd_level) begin
                    state_nxt.phase = ST_WAIT;
                end
            end
            ST_WAIT: begin
                state_nxt.delay_cnt = state_r.delay_cnt + 32'd1;
                if (host_control_select_pin_i) begin
                    state_nxt.phase = ST_RUN;
                end else if (state_r.delay_cnt >= 32'(INIT_DELAY - 1)) begin
                    state_nxt.phase = ST_INITIAL;
                end
            end
            ST_INITIAL: begin
                if (eff_mode == voice_ctrl_pkg::MODE_HANDSFREE
                    || eff_mode == voice_ctrl_pkg::MODE_LINE_EXP) begin
                    state_nxt.phase = ST_RUN;
                    state_nxt.hiz = 1'b0;
                end
            end
            ST_RUN: begin
                state_nxt.hiz = 1'b0;
            end
            default: state_nxt.phase = ST_RESET;
        endcase
        if (pd_level && state_r.phase != ST_RESET) begin
            state_nxt.phase = ST_RESET;
        end
        if (rst_level) begin
            // Reset bit or pin: all control registers back to zero
            state_nxt.basic_mode  = voice_ctrl_pkg::RESET_VALUE;
            state_nxt.codec_path  = voice_ctrl_pkg::RESET_VALUE;
            state_nxt.slot_assign = voice_ctrl_pkg::RESET_VALUE;
            state_nxt.routing     = voice_ctrl_pkg::RESET_VALUE;
            state_nxt.tone_gain   = voice_ctrl_pkg::RESET_VALUE;
            state_nxt.tone_select = voice_ctrl_pkg::RESET_VALUE;
            state_nxt.phase       = ST_RESET;
            state_nxt.hiz         = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= '0;
            state_r.phase <= ST_RESET;
            state_r.hiz <= 1'b1;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    logic active;
    assign active = state_r.phase == ST_RUN;

    assign bus.rdata                = state_r.rdata;
    assign bus.rdata_oe             = rd_active;
    assign powered_down_o           = pd_level || rst_level;
    assign in_reset_o               = state_r.phase == ST_RESET;
    assign initial_mode_o           = state_r.phase == ST_INITIAL;
    assign operating_mode_code_o    = eff_mode;
    assign handsfree_o              = active && eff_mode == voice_ctrl_pkg::MODE_HANDSFREE;
    assign line_expansion_o         = active && eff_mode == voice_ctrl_pkg::MODE_LINE_EXP;
    assign canceler_enable_o        = (handsfree_o || line_expansion_o)
                                      && !whole_path_through_o;
    assign transcoder_enable_o      = canceler_enable_o && !codec_through_o;
    assign pcm_idle_o               = !active;
    assign pcm_out_hiz_o            = state_r.hiz;
    assign codec_through_o          = state_r.codec_path[voice_ctrl_pkg::POS_CODEC_THROUGH]
                                      && !codec_through_pin_i;
    assign transcoder_state_reset_o = state_r.xcoder_reset;
    assign whole_path_through_o     = state_r.codec_path[voice_ctrl_pkg::POS_WHOLE_THROUGH];
    assign tx_mute_o                = state_r.codec_path[voice_ctrl_pkg::POS_TX_MUTE]
                                      && !whole_path_through_o;
    assign receive_attenuation_code_o =
        (state_r.codec_path[voice_ctrl_pkg::POS_RX_MUTE] && !mute_pin_i
         && !whole_path_through_o) ? state_r.codec_path[2:0] : 3'h0;
    assign rx_full_mute_o           = receive_attenuation_code_o
                                      == voice_ctrl_pkg::ATTEN_MUTE;
    assign transcoder_slot_o        = {1'b0, state_r.slot_assign[voice_ctrl_pkg::POS_XCODER_SLOT]};
    assign line_canceler_slot_select_o     = state_r.slot_assign[3:2];
    assign acoustic_canceler_slot_select_o = state_r.slot_assign[1:0];
    assign pcm_io_routing_o         = state_r.routing[6:5];
    assign transmit_tone_gain_o     = state_r.tone_gain[7:4];
    assign receive_tone_gain_o      = state_r.tone_gain[3:0];
    assign dual_tone_select_o       = state_r.tone_select[voice_ctrl_pkg::POS_DUAL_TONE];
    assign tx_tone_send_o           = state_r.tone_select[voice_ctrl_pkg::POS_TX_TONE_SEND];
    assign rx_tone_send_o           = state_r.tone_select[voice_ctrl_pkg::POS_RX_TONE_SEND];
    assign tone_code_o              = state_r.tone_select[4:0];
endmodule
`default_nettype wire

// File: rtl/voice_ctrl_host.sv
// Host controller end: Wishbone slave that drives the parallel register port
`timescale 1ns/1ns
`default_nettype none
module voice_ctrl_host (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [4:0]  adr_i,
    input  wire logic [31:0] dat_i,
    input  wire logic [3:0]  sel_i,
    output logic [31:0]      dat_o,
    output logic             ack_o,
    voice_ctrl_if.host       bus
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum logic [1:0] {ST_IDLE, ST_STROBE, ST_HOLD, ST_DONE} phase_t;

    typedef struct packed {
        phase_t      phase;
        logic        cs_n;
        logic        wr_n;
        logic        rd_n;
        logic [4:0]  addr;
        logic [7:0]  wdata;
        logic        pd_n;
        logic        pdr_n;
        logic [31:0] rdata;
        logic        ack;
    } state_t;

    state_t state_r;
    state_t state_nxt;

    logic req;
    assign req = cyc_i && stb_i && !state_r.ack;

    always_comb begin
        state_nxt = state_r;
        state_nxt.ack = 1'b0;
        case (state_r.phase)
            ST_IDLE: begin
                if (req && adr_i == voice_ctrl_pkg::IDX_COMMAND) begin
                    // Own pin levels; hold at 1 when using the register bits
                    if (we_i && sel_i[0]) begin
                        state_nxt.pd_n  = dat_i[0];
                        state_nxt.pdr_n = dat_i[1];
                    end
                    state_nxt.rdata = {30'h0, state_r.pdr_n, state_r.pd_n};
                    state_nxt.ack = 1'b1;
                    state_nxt.phase = ST_DONE;
                end else if (req && adr_i <= voice_ctrl_pkg::IDX_LAST) begin
                    // No select for a write that carries no byte lane
                    state_nxt.cs_n  = we_i && !sel_i[0];
                    state_nxt.wr_n  = !(we_i && sel_i[0]);
                    state_nxt.rd_n  = we_i;
                    state_nxt.addr  = adr_i;
                    state_nxt.wdata = dat_i[7:0];
                    state_nxt.phase = ST_STROBE;
                end else if (req) begin
                    state_nxt.rdata = 32'h0;
                    state_nxt.ack = 1'b1;
                    state_nxt.phase = ST_DONE;
                end
            end
            ST_STROBE: begin
                state_nxt.cs_n = 1'b1;
                state_nxt.wr_n = 1'b1;
                state_nxt.rd_n = 1'b1;
                state_nxt.phase = ST_HOLD;
            end
            // Device registers read data one edge after the address
            ST_HOLD: begin
                state_nxt.rdata = {24'h0, bus.rdata};
                state_nxt.ack = 1'b1;
                state_nxt.phase = ST_DONE;
            end
            ST_DONE: state_nxt.phase = ST_IDLE;
            default: state_nxt.phase = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= '0;
            state_r.phase <= ST_IDLE;
            state_r.cs_n <= 1'b1;
            state_r.wr_n <= 1'b1;
            state_r.rd_n <= 1'b1;
            state_r.pd_n <= 1'b1;
            state_r.pdr_n <= 1'b1;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign dat_o                 = state_r.rdata;
    assign ack_o                 = state_r.ack;
    assign bus.cs_n              = state_r.cs_n;
    assign bus.wr_n              = state_r.wr_n;
    assign bus.rd_n              = state_r.rd_n;
    assign bus.addr              = state_r.addr;
    assign bus.wdata             = state_r.wdata;
    assign bus.powerdown_n       = state_r.pd_n;
    assign bus.powerdown_reset_n = state_r.pdr_n;
endmodule
`default_nettype wire

// File: sim/voice_ctrl_assertions.sv
// Checker on the parallel port between host end and device end
`timescale 1ns/1ns
`default_nettype none
module voice_ctrl_assertions (
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic       cs_n,
    input wire logic       wr_n,
    input wire logic       rd_n,
    input wire logic [4:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic       rdata_oe,
    input wire logic       powerdown_n,
    input wire logic       powerdown_reset_n
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ----------
    // Bits that exist in each register
    // ----------
    function automatic logic [7:0] used(input logic [4:0] a);
        case (a)
            5'h00:   used = 8'h6f;
            5'h02:   used = 8'h1f;
            5'h03:   used = 8'h60;
            default: used = 8'hff;
        endcase
    endfunction
    sequence s_wr; !cs_n && !wr_n; endsequence
    sequence s_rd; !cs_n && !rd_n; endsequence
    property p_oe; s_rd |-> rdata_oe && addr <= 5'h05; endproperty
    property p_idle;
        @(posedge clk_i) disable iff (1'b0)
        $fell(rst_i) |-> cs_n && wr_n && rd_n && powerdown_n && powerdown_reset_n;
    endproperty
    property p_both; !(!wr_n && !rd_n); endproperty
    property p_wr1; s_wr |=> cs_n && wr_n && $stable(wdata); endproperty
    property p_rd1; s_rd |=> cs_n && rd_n && $stable(addr); endproperty
    property p_qual; !cs_n |-> (!wr_n || !rd_n); endproperty
    property p_unused; s_rd |=> (rdata & ~used($past(addr))) == 8'h00; endproperty
    property p_clear;
        s_rd ##0 (!powerdown_reset_n && !$past(powerdown_reset_n)) |=> rdata == 8'h00;
    endproperty
    a_oe: assert property (p_oe) else $error("read enable off its strobe");
    a_idle: assert property (p_idle) else $error("port not idle after reset");
    a_both: assert property (p_both) else $error("write and read strobes together");
    a_wr1: assert property (p_wr1) else $error("write strobe not single cycle");
    a_rd1: assert property (p_rd1) else $error("read strobe not single cycle");
    a_qual: assert property (p_qual) else $error("select without strobe");
    a_unused: assert property (p_unused) else $error("unused bit read as one");
    a_clear: assert property (p_clear) else $error("register kept during reset");
endmodule
`default_nettype wire

// File: sim/echo_adpcm_control_regs_tb_top.sv
// Self-checking bench joining host end and device end of the control port
`timescale 1ns/1ns
`default_nettype none
module echo_adpcm_control_regs_tb_top;
    localparam int DLY = 10;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc_i, stb_i, we_i, ack_o, sel_pin, echo_pin, ct_pin, mute_pin;
    logic [4:0]  adr_i, a, tone_code_o;
    logic [31:0] dat_i, dat_o;
    logic [3:0]  sel_i, operating_mode_code_o, transmit_tone_gain_o, receive_tone_gain_o;
    logic [7:0]  q, d;
    logic        powered_down_o, in_reset_o, initial_mode_o, handsfree_o, line_expansion_o;
    logic        canceler_enable_o, transcoder_enable_o, pcm_idle_o, pcm_out_hiz_o;
    logic        codec_through_o, transcoder_state_reset_o, whole_path_through_o, tx_mute_o;
    logic        rx_full_mute_o, dual_tone_select_o, tx_tone_send_o, rx_tone_send_o;
    logic [2:0]  receive_attenuation_code_o;
    logic [1:0]  transcoder_slot_o, line_canceler_slot_select_o;
    logic [1:0]  acoustic_canceler_slot_select_o, pcm_io_routing_o;
    int          n_fail = 0, total_checks = 0, n_pulse = 0, exp_pulse = 0, seed;
    voice_ctrl_if vif ();
    voice_ctrl_host u_voice_ctrl_host (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .dat_i,
        .sel_i, .dat_o, .ack_o, .bus(vif.host));
    voice_ctrl_regs #(.INIT_DELAY(DLY)) u_voice_ctrl_regs (.clk_i, .rst_i, .bus(vif.device),
        .host_control_select_pin_i(sel_pin), .echo_mode_pin_i(echo_pin),
        .codec_through_pin_i(ct_pin), .mute_pin_i(mute_pin), .powered_down_o, .in_reset_o,
        .initial_mode_o, .operating_mode_code_o, .handsfree_o, .line_expansion_o,
        .canceler_enable_o, .transcoder_enable_o, .pcm_idle_o, .pcm_out_hiz_o,
        .codec_through_o, .transcoder_state_reset_o, .whole_path_through_o, .tx_mute_o,
        .receive_attenuation_code_o, .rx_full_mute_o, .transcoder_slot_o,
        .line_canceler_slot_select_o, .acoustic_canceler_slot_select_o, .pcm_io_routing_o,
        .transmit_tone_gain_o, .receive_tone_gain_o, .dual_tone_select_o, .tx_tone_send_o,
        .rx_tone_send_o, .tone_code_o);
    voice_ctrl_assertions u_voice_ctrl_assertions (.clk_i, .rst_i, .cs_n(vif.cs_n),
        .wr_n(vif.wr_n), .rd_n(vif.rd_n), .addr(vif.addr), .wdata(vif.wdata),
        .rdata(vif.rdata), .rdata_oe(vif.rdata_oe), .powerdown_n(vif.powerdown_n),
        .powerdown_reset_n(vif.powerdown_reset_n));
    always #5 clk_i = ~clk_i;
    always @(posedge clk_i) if (transcoder_state_reset_o === 1'b1) n_pulse++;
    // ----------
    // Bus cycles, expectations and comparisons
    // ----------
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wb(input logic w, input logic [4:0] ad, input logic [7:0] dd);
        int n;
        n = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= ad;
        dat_i <= {24'($urandom), dd};
        sel_i <= {3'($urandom), 1'b1};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 40);
        if (n >= 40) n_fail++;
        q = dat_o[7:0];
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [4:0] ad, input logic [7:0] e);
        wb(1'b0, ad, 8'h00);
        chk("read", e, q);
    endtask
    function automatic logic [7:0] keep(input logic [4:0] ad, input logic [7:0] v);
        case (ad)
            5'h00:   keep = v & 8'h6f;
            5'h02:   keep = v & 8'h1f;
            5'h03:   keep = v & 8'h60;
            default: keep = v;
        endcase
    endfunction
    task automatic fields(input logic [4:0] ad, input logic [7:0] v);
        logic [2:0] att;
        att = (v[3] && !mute_pin && !v[5]) ? v[2:0] : 3'h0;
        case (ad)
            5'h00: chk("mode", v[3:0] | {1'b0, sel_pin, 1'b0, echo_pin}, operating_mode_code_o);
            5'h01: begin
                chk("thru", v[7] & !ct_pin, codec_through_o);
                chk("whole", v[5], whole_path_through_o);
                chk("txmute", v[4] & !v[5], tx_mute_o);
                chk("atten", att, receive_attenuation_code_o);
                chk("rxmute", att == 3'h7, rx_full_mute_o);
            end
            5'h02: begin
                chk("adslot", {1'b0, v[4]}, transcoder_slot_o);
                chk("slots", v[3:0], {line_canceler_slot_select_o, acoustic_canceler_slot_select_o});
            end
            5'h03: chk("route", v[6:5], pcm_io_routing_o);
            5'h04: chk("gain", v, {transmit_tone_gain_o, receive_tone_gain_o});
            default: chk("tone", v, {dual_tone_select_o, tx_tone_send_o, rx_tone_send_o, tone_code_o});
        endcase
    endtask
    task automatic test_done();
        if (n_fail == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // ----------
    // Main sequence and watchdog
    // ----------
    initial begin
        {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} = '0;
        {sel_pin, echo_pin, ct_pin, mute_pin} = 4'h0;
        seed = $urandom(32'hdf7e);
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk("hiz", 1'b1, pcm_out_hiz_o);
        for (int i = 0; i < 6; i++) rd(5'(i), 8'h00);
        for (int k = 0; k < 40; k++) begin
            a = 5'($urandom_range(5));
            d = 8'($urandom);
            {sel_pin, echo_pin, ct_pin, mute_pin} <= 4'($urandom);
            if (a == 5'h00) d = d & 8'h9f;
            if (a == 5'h01 && d[6]) exp_pulse++;
            wb(1'b1, a, d);
            rd(a, keep(a, d));
            fields(a, keep(a, d));
        end
        {sel_pin, echo_pin, ct_pin, mute_pin} <= 4'h0;
        wb(1'b1, 5'h04, 8'ha5);
        wb(1'b1, 5'h00, 8'h40);
        chk("global_powerdown", 1'b1, powered_down_o);
        chk("inrst", 1'b1, in_reset_o);
        rd(5'h04, 8'ha5);
        wb(1'b1, 5'h00, 8'h2f);
        rd(5'h00, 8'h00);
        rd(5'h04, 8'h00);
        wb(1'b1, 5'h09, 8'hff);
        rd(5'h09, 8'h00);
        rd(5'h06, 8'h00);
        for (int s = 1; s >= 0; s--) begin
            wb(1'b1, 5'h04, 8'h3c);
            wb(1'b1, 5'h07, 8'h01);
            chk("pdrst", 1'b1, powered_down_o);
            rd(5'h04, 8'h00);
            sel_pin <= s[0];
            wb(1'b1, 5'h07, 8'h03);
            chk("wait", 1'b0, initial_mode_o);
            repeat (DLY + 5) @(posedge clk_i);
            chk("init", !s[0], initial_mode_o);
            chk("hands", s[0], handsfree_o);
            chk("idle", !s[0], pcm_idle_o);
            chk("xcen", s[0], transcoder_enable_o);
        end
        chk("hiz0", 1'b1, pcm_out_hiz_o);
        wb(1'b1, 5'h00, 8'h04);
        chk("run", 1'b0, initial_mode_o);
        chk("hands4", 1'b1, handsfree_o);
        chk("cancel", 1'b1, canceler_enable_o);
        wb(1'b1, 5'h00, 8'h05);
        chk("line5", 1'b1, line_expansion_o);
        chk("hands5", 1'b0, handsfree_o);
        chk("xrst", 8'(exp_pulse), 8'(n_pulse));
        test_done();
    end
    initial begin
        repeat (5000) @(posedge clk_i);
        n_fail++;
        test_done();
    end
endmodule
`default_nettype wire
